// ### sdcbc_top.sv
// Command decoder, burst engine and refresh logic of a four-bank synchronous DRAM.
// Assumes a controller drives the pins on link_clk and the array core answers reads
// combinationally on arr_rdata; mclk is the free running internal clock.
`timescale 1ns/1ps
`default_nettype none
module sdcbc_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_0,
  input wire logic bank_select_1,
  input wire logic [12:0] addr,
  input wire logic [1:0] dqm,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe_n,
  output logic arr_rd,
  output logic arr_we,
  output logic [1:0] arr_bank,
  output logic [12:0] arr_row,
  output logic [8:0] arr_col,
  output logic [15:0] arr_wdata,
  output logic [1:0] arr_wmask,
  input wire logic [15:0] arr_rdata,
  output logic [11:0] mode_word,
  output logic [3:0] bank_open,
  output logic self_refresh,
  output logic self_refresh_seen,
  output logic refresh_pulse,
  output logic [12:0] refresh_row
);

  // Link clock domain state.
  typedef struct packed {
    logic [11:0] mode;
    logic sref;
    logic ar_tgl;
    logic bact;
    logic bwr;
    logic bap;
    logic [1:0] bbank;
    logic [8:0] bstart;
    logic [8:0] bidx;
    logic arr_rd;
    logic arr_we;
    logic [1:0] arr_bank;
    logic [12:0] arr_row;
    logic [8:0] arr_col;
    logic [15:0] arr_wdata;
    logic [1:0] arr_wmask;
    logic rv1;
    logic [15:0] rp1;
    logic [1:0] dqm_reg;
    logic [15:0] dq_out;
    logic [1:0] dq_oe_n;
  } sdcbc_link_s;

  // Internal clock domain state.
  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    logic q1;
    logic q2;
    logic [7:0] tick;
    logic [12:0] row;
    logic pulse;
  } sdcbc_int_s;

  sdcbc_link_s lk_reg;
  sdcbc_link_s lk_next;
  sdcbc_int_s in_reg;
  sdcbc_int_s in_next;

  sdcbc_bank_if bif ();

  // Open flag and open row of each bank live in the tracker.
  sdcbc_bank_track u_track (
    .clk(link_clk),
    .arst_n(arst_n),
    .bif(bif)
  );

  // Mask of the column bits that wrap inside a burst.
  function automatic logic [8:0] burst_mask(input logic [2:0] code);
    logic [8:0] m;
    m = 9'h000;
    unique case (code)
      3'h1: m = 9'h001;
      3'h2: m = 9'h003;
      3'h3: m = 9'h007;
      3'h7: m = 9'h1ff;
      default: m = 9'h000;
    endcase
    return m;
  endfunction

  // Column of element idx of a burst that starts at start.
  function automatic logic [8:0] burst_col(input logic [8:0] start, input logic [8:0] idx,
                                           input logic [8:0] m, input logic ilv);
    logic [8:0] off;
    off = ilv ? (start ^ idx) : 9'(start + idx);
    return (start & ~m) | (off & m);
  endfunction

  sdcbc_pkg::sdcbc_cmd_e cmd;
  logic [1:0] bsel;
  logic [8:0] mask;
  logic full;
  logic ilv;
  logic cl2;
  logic vld;
  logic is_wr;

  always_comb begin
    // Decode this edge's command and the fields of the mode word.
    cmd = sdcbc_pkg::decode_cmd(cs_n, ras_n, cas_n, we_n);
    bsel = {bank_select_1, bank_select_0};
    mask = burst_mask(lk_reg.mode[sdcbc_pkg::MODE_BL_MSB:sdcbc_pkg::MODE_BL_LSB]);
    full = lk_reg.mode[sdcbc_pkg::MODE_BL_MSB:sdcbc_pkg::MODE_BL_LSB] == sdcbc_pkg::BL_FULL;
    ilv = lk_reg.mode[sdcbc_pkg::MODE_BT_BIT] && !full;
    cl2 = lk_reg.mode[sdcbc_pkg::MODE_CL_MSB:sdcbc_pkg::MODE_CL_LSB] == sdcbc_pkg::CL_TWO;
    is_wr = cmd == sdcbc_pkg::CMD_WR;
    lk_next = lk_reg;
    lk_next.arr_rd = 1'b0;
    lk_next.arr_we = 1'b0;
    lk_next.dqm_reg = dqm;
    bif.act = 1'b0;
    bif.act_bank = bsel;
    bif.act_row = addr;
    bif.pre = 1'b0;
    bif.pre_all = addr[sdcbc_pkg::ADDR_AP_BIT];
    bif.pre_bank = bsel;
    bif.ap = 1'b0;
    bif.ap_bank = lk_reg.bbank;

    // Read data path: CL of two drives the array word one clock after the read.
    lk_next.rv1 = lk_reg.arr_rd;
    lk_next.rp1 = arr_rdata;
    vld = cl2 ? lk_reg.arr_rd : lk_reg.rv1;
    lk_next.dq_out = cl2 ? arr_rdata : lk_reg.rp1;
    for (int b = 0; b < sdcbc_pkg::BYTES; b++) begin
      lk_next.dq_oe_n[b] = !(vld && !lk_reg.dqm_reg[b]);
    end

    // Burst in progress keeps running whatever no-op arrives.
    if (lk_reg.bact) begin
      lk_next.arr_bank = lk_reg.bbank;
      lk_next.arr_row = bif.rows[lk_reg.bbank];
      lk_next.arr_col = burst_col(lk_reg.bstart, lk_reg.bidx, mask, ilv);
      lk_next.bidx = 9'(lk_reg.bidx + 9'h001);
      if (lk_reg.bwr) begin
        lk_next.arr_we = 1'b1;
        lk_next.arr_wdata = dq_in;
        lk_next.arr_wmask = dqm;
      end else begin
        lk_next.arr_rd = 1'b1;
      end
      if (!full && lk_reg.bidx == mask) begin
        lk_next.bact = 1'b0;
        bif.ap = lk_reg.bap;
      end
    end

    if (lk_reg.sref) begin
      // Only clock enable is looked at while refreshing internally.
      lk_next.bact = 1'b0;
      if (cke) begin
        lk_next.sref = 1'b0;
      end
    end else if (!cke) begin
      if (cmd == sdcbc_pkg::CMD_REF) begin
        lk_next.sref = 1'b1;
        lk_next.bact = 1'b0;
        lk_next.arr_rd = 1'b0;
        lk_next.arr_we = 1'b0;
      end
    end else begin
      unique case (cmd)
        sdcbc_pkg::CMD_NONE: begin
          lk_next.sref = 1'b0;
        end
        sdcbc_pkg::CMD_MRS: begin
          lk_next.mode = addr[11:0];
        end
        sdcbc_pkg::CMD_ACT: begin
          bif.act = 1'b1;
        end
        sdcbc_pkg::CMD_RD, sdcbc_pkg::CMD_WR: begin
          // A new read or write to an open bank replaces any burst that is still running.
          if (bif.open_banks[bsel]) begin
            lk_next.bbank = bsel;
            lk_next.bstart = addr[8:0];
            lk_next.bwr = is_wr;
            lk_next.bap = addr[sdcbc_pkg::ADDR_AP_BIT] && !full;
            lk_next.bidx = 9'h001;
            lk_next.bact = mask != 9'h000;
            lk_next.arr_bank = bsel;
            lk_next.arr_row = bif.rows[bsel];
            lk_next.arr_col = burst_col(addr[8:0], 9'h000, mask, ilv);
            lk_next.arr_rd = !is_wr;
            lk_next.arr_we = is_wr;
            lk_next.arr_wdata = dq_in;
            lk_next.arr_wmask = dqm;
            if (mask == 9'h000 && addr[sdcbc_pkg::ADDR_AP_BIT] && !full) begin
              bif.ap = 1'b1;
              bif.ap_bank = bsel;
            end else begin
              bif.ap = 1'b0;
            end
            if (is_wr) begin
              lk_next.rv1 = 1'b0;
              lk_next.dq_oe_n = 2'h3;
            end
          end
        end
        sdcbc_pkg::CMD_BST: begin
          lk_next.bact = 1'b0;
          lk_next.arr_rd = 1'b0;
          lk_next.arr_we = 1'b0;
          bif.ap = 1'b0;
        end
        sdcbc_pkg::CMD_PRE: begin
          bif.pre = 1'b1;
          // A precharge to the burst's bank, or to all banks, cuts the burst here.
          if (lk_reg.bact && (addr[sdcbc_pkg::ADDR_AP_BIT] || bsel == lk_reg.bbank)) begin
            lk_next.bact = 1'b0;
            lk_next.arr_rd = 1'b0;
            lk_next.arr_we = 1'b0;
          end
        end
        sdcbc_pkg::CMD_REF: begin
          lk_next.ar_tgl = !lk_reg.ar_tgl;
        end
      endcase
    end
  end

  // Output enables reset high so the data pins start released.
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lk_reg <= '0;
      lk_reg.mode <= sdcbc_pkg::MODE_RESET;
      lk_reg.dq_oe_n <= 2'h3;
      lk_reg.arr_wmask <= 2'h3;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // Internal clock side: refresh row counter shared by both refresh modes.
  logic fire;

  always_comb begin
    in_next = in_reg;
    // The refresh toggle and the self refresh flag each pass two flip-flops before use.
    in_next.t1 = lk_reg.ar_tgl;
    in_next.t2 = in_reg.t1;
    in_next.t3 = in_reg.t2;
    in_next.q1 = lk_reg.sref;
    in_next.q2 = in_reg.q1;
    in_next.pulse = 1'b0;
    fire = 1'b0;
    // The internal tick runs only while the synchronised self refresh flag is set.
    if (in_reg.q2) begin
      if (in_reg.tick == sdcbc_pkg::REFRESH_LAST) begin
        in_next.tick = 8'h00;
        fire = 1'b1;
      end else begin
        in_next.tick = 8'(in_reg.tick + 8'h01);
      end
    end else begin
      in_next.tick = 8'h00;
    end
    // An edge of the synchronised toggle marks one auto refresh from the link side.
    if ((in_reg.t2 ^ in_reg.t3) || fire) begin
      in_next.row = 13'(in_reg.row + 13'h0001);
      in_next.pulse = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      in_reg <= '0;
    end else begin
      in_reg <= in_next;
    end
  end

  // Every output comes straight from a register.
  assign dq_out = lk_reg.dq_out;
  assign dq_oe_n = lk_reg.dq_oe_n;
  assign arr_rd = lk_reg.arr_rd;
  assign arr_we = lk_reg.arr_we;
  assign arr_bank = lk_reg.arr_bank;
  assign arr_row = lk_reg.arr_row;
  assign arr_col = lk_reg.arr_col;
  assign arr_wdata = lk_reg.arr_wdata;
  assign arr_wmask = lk_reg.arr_wmask;
  assign mode_word = lk_reg.mode;
  assign bank_open = bif.open_banks;
  assign self_refresh = lk_reg.sref;
  assign self_refresh_seen = in_reg.q2;
  assign refresh_pulse = in_reg.pulse;
  assign refresh_row = in_reg.row;

endmodule
`default_nettype wire

// ### sdcbc_pkg.sv
// Package for the synchronous DRAM command and bank control block.
// Assumes a x16 organisation with four banks and a 25 MHz mclk.
package sdcbc_pkg;

  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int DQ_W = 16;
  localparam int BYTES = 2;
  localparam int BANKS = 4;
  localparam int MODE_W = 12;

  // Mode word fields and reset value.
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BL_MSB = 2;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_CL_MSB = 6;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h020;
  localparam logic [2:0] CL_TWO = 3'h2;
  localparam logic [2:0] BL_FULL = 3'h7;

  // Address pin that carries auto precharge and all-bank select.
  localparam int ADDR_AP_BIT = 10;

  // Internal refresh interval used while in self refresh.
  localparam int MCLK_PERIOD_NS = 40;
  localparam int REFRESH_INTERVAL_NS = 7810;
  localparam int REFRESH_TICKS = REFRESH_INTERVAL_NS / MCLK_PERIOD_NS;
  localparam logic [7:0] REFRESH_LAST = 8'(REFRESH_TICKS - 1);

  typedef enum logic [2:0] {
    CMD_NONE, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF, CMD_MRS
  } sdcbc_cmd_e;

  // Decodes the command pins into one command.
  function automatic sdcbc_cmd_e decode_cmd(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
    sdcbc_cmd_e c;
    c = CMD_NONE;
    if (!cs_n) begin
      unique case ({ras_n, cas_n, we_n})
        3'h3: c = CMD_ACT;
        3'h5: c = CMD_RD;
        3'h4: c = CMD_WR;
        3'h6: c = CMD_BST;
        3'h2: c = CMD_PRE;
        3'h1: c = CMD_REF;
        3'h0: c = CMD_MRS;
        3'h7: c = CMD_NONE;
      endcase
    end
    return c;
  endfunction

endpackage

// ### sdcbc_bank_if.sv
// Interface between the command logic and the bank tracker.
// Assumes both ends run on the link clock.
`timescale 1ns/1ps
`default_nettype none
interface sdcbc_bank_if;
  logic act;
  logic [1:0] act_bank;
  logic [12:0] act_row;
  logic pre;
  logic pre_all;
  logic [1:0] pre_bank;
  logic ap;
  logic [1:0] ap_bank;
  logic [3:0] open_banks;
  logic [3:0][12:0] rows;
  modport ctrl (output act, act_bank, act_row, pre, pre_all, pre_bank, ap, ap_bank,
                input open_banks, rows);
  modport track (input act, act_bank, act_row, pre, pre_all, pre_bank, ap, ap_bank,
                 output open_banks, rows);
endinterface
`default_nettype wire

// ### sdcbc_bank_track.sv
// Bank tracker: open flag and open row of each bank.
// Assumes requests arrive on the link clock through the bank interface.
`timescale 1ns/1ps
`default_nettype none
module sdcbc_bank_track (
  input wire logic clk,
  input wire logic arst_n,
  sdcbc_bank_if.track bif
);

  typedef struct packed {
    logic [3:0] open_banks;
    logic [3:0][12:0] rows;
  } sdcbc_bank_s;

  sdcbc_bank_s st_reg;
  sdcbc_bank_s st_next;

  always_comb begin
    st_next = st_reg;
    if (bif.ap) begin
      st_next.open_banks[bif.ap_bank] = 1'b0;
    end
    if (bif.pre) begin
      if (bif.pre_all) begin
        st_next.open_banks = 4'h0;
      end else begin
        st_next.open_banks[bif.pre_bank] = 1'b0;
      end
    end
    // An activate in the same cycle as a closing request wins.
    if (bif.act) begin
      st_next.open_banks[bif.act_bank] = 1'b1;
      st_next.rows[bif.act_bank] = bif.act_row;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bif.open_banks = st_reg.open_banks;
  assign bif.rows = st_reg.rows;

endmodule
`default_nettype wire

// ### sdcbc_top_asserts.sv
// Concurrent checks on the link side pins and array outputs of sdcbc_top.
// Assumes it is bound into sdcbc_top and watches the link clock domain only.
`timescale 1ns/1ps
`default_nettype none
module sdcbc_top_asserts (
  input wire logic link_clk,
  input wire logic arst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_0,
  input wire logic bank_select_1,
  input wire logic [12:0] addr,
  input wire logic [1:0] dqm,
  input wire logic [15:0] dq_in,
  input wire logic [1:0] dq_oe_n,
  input wire logic arr_rd,
  input wire logic arr_we,
  input wire logic [1:0] arr_bank,
  input wire logic [8:0] arr_col,
  input wire logic [15:0] arr_wdata,
  input wire logic [1:0] arr_wmask,
  input wire logic [11:0] mode_word,
  input wire logic [3:0] bank_open,
  input wire logic self_refresh
);
  logic go;
  logic [1:0] ba;
  logic [2:0] c;
  assign go = cke && !self_refresh && !cs_n;
  assign ba = {bank_select_1, bank_select_0};
  assign c = {ras_n, cas_n, we_n};
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd_cl2;
    go && c == 3'h5 && bank_open[ba] && mode_word[6:4] == 3'h2;
  endsequence
  sequence s_two_later;
    ##2 dq_oe_n == $past(dqm, 2);
  endsequence
  a_deselect_holds_mode: assert property (cs_n |=> $stable(mode_word)) else $error("mode changed while deselected");
  a_mode_load_capture: assert property (go && c == 3'h0 |=> mode_word == $past(addr[11:0]))
    else $error("mode word not captured");
  a_act_opens_bank: assert property (go && c == 3'h3 |=> bank_open[$past(ba)]) else $error("bank not opened");
  a_pre_all_closes: assert property (go && c == 3'h2 && addr[10] |=> bank_open == 4'h0)
    else $error("banks not all closed");
  a_pre_one_closes: assert property (go && c == 3'h2 && !addr[10] |=> !bank_open[$past(ba)])
    else $error("bank not closed");
  a_read_starts: assert property (go && c == 3'h5 && bank_open[ba] |=> arr_rd && arr_bank == $past(ba)
    && arr_col == $past(addr[8:0])) else $error("read burst start wrong");
  a_write_mask_data: assert property (go && c == 3'h4 && bank_open[ba] |=> arr_we && arr_wmask == $past(dqm)
    && arr_wdata == $past(dq_in)) else $error("write element wrong");
  a_read_mask_lat: assert property (s_rd_cl2 |-> s_two_later) else $error("read mask latency wrong");
  a_bst_stops_burst: assert property (go && c == 3'h6 |=> !arr_rd && !arr_we) else $error("burst not stopped");
  a_self_ref_entry: assert property (!cs_n && !cke && !self_refresh && c == 3'h1 |=> self_refresh)
    else $error("self refresh not entered");
  a_self_ref_hold: assert property (self_refresh && !cke |=> self_refresh) else $error("self refresh left early");
endmodule
bind sdcbc_top sdcbc_top_asserts sdcbc_top_asserts_inst (.link_clk, .arst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
  .bank_select_0, .bank_select_1, .addr, .dqm, .dq_in, .dq_oe_n, .arr_rd, .arr_we, .arr_bank, .arr_col,
  .arr_wdata, .arr_wmask, .mode_word, .bank_open, .self_refresh);
`default_nettype wire

// ### sdcbc_array_model.sv
// Behavioural array core that answers the block's array port.
// Assumes one row per column address is enough; bank and row are not decoded.
`timescale 1ns/1ps
`default_nettype none
module sdcbc_array_model (
  input wire logic clk,
  input wire logic arr_we,
  input wire logic [8:0] arr_col,
  input wire logic [15:0] arr_wdata,
  input wire logic [1:0] arr_wmask,
  output logic [15:0] arr_rdata
);
  logic [15:0] mem [512];
  initial begin
    foreach (mem[k]) mem[k] = 16'ha5a5;
  end
  assign arr_rdata = mem[arr_col];
  always @(posedge clk) begin
    for (int b = 0; b < 2; b++) begin
      if (arr_we && !arr_wmask[b]) mem[arr_col][8*b+:8] <= arr_wdata[8*b+:8];
    end
  end
endmodule
`default_nettype wire

// ### test_sdcbc_top.sv
// Self-checking bench for sdcbc_top: commands on the link pins, checks at the ports.
// Assumes the array model answers reads and the design resets to a CL2 mode word.
`timescale 1ns/1ps
`default_nettype none
module test_sdcbc_top;
  logic mclk, link_clk, lk_run, arst_n, cke, cs_n, ras_n, cas_n, we_n, bank_select_0, bank_select_1;
  logic arr_rd, arr_we, self_refresh, self_refresh_seen, refresh_pulse;
  logic [12:0] addr, arr_row, refresh_row, r0;
  logic [15:0] dq_in, dq_out, arr_wdata, arr_rdata, mk;
  logic [1:0] dqm, dq_oe_n, arr_bank, arr_wmask;
  logic [8:0] arr_col;
  logic [11:0] mode_word;
  logic [3:0] bank_open;
  logic [15:0] rd_exp [4];
  int mismatches, checks_done, ticks, n;
  sdcbc_top sdcbc_top_inst (.mclk, .arst_n, .link_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_0,
    .bank_select_1, .addr, .dqm, .dq_in, .dq_out, .dq_oe_n, .arr_rd, .arr_we, .arr_bank, .arr_row, .arr_col,
    .arr_wdata, .arr_wmask, .arr_rdata, .mode_word, .bank_open, .self_refresh, .self_refresh_seen,
    .refresh_pulse, .refresh_row);
  sdcbc_array_model sdcbc_array_model_inst (.clk(link_clk), .arr_we, .arr_col, .arr_wdata, .arr_wmask,
    .arr_rdata);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever begin
      #80;
      if (lk_run) link_clk = ~link_clk;
    end
  end
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a, input logic [1:0] m,
                     input logic [15:0] d);
    @(negedge link_clk);
    {cs_n, ras_n, cas_n, we_n} = c;
    {bank_select_1, bank_select_0} = ba;
    addr = a;
    dqm = m;
    dq_in = d;
  endtask
  task automatic nop(input int k);
    repeat (k) cmd(4'h7, 2'h0, ~addr, 2'h0, ~dq_in);
  endtask
  initial begin
    lk_run = 1'b1;
    arst_n = 1'b0;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n, bank_select_0, bank_select_1} = 6'h3c;
    addr = 13'h0;
    dqm = 2'h0;
    dq_in = 16'h0;
    {mismatches, checks_done, ticks} = '0;
    rd_exp = '{16'h4444, 16'h1111, 16'h22a5, 16'h3333};
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    chk("mode_word", 16'h0020, 16'(mode_word));
    chk("bank_open", 16'h0, 16'(bank_open));
    cmd(4'h0, 2'h0, 13'h0022, 2'h0, 16'h0);
    cmd(4'h8, 2'h0, 13'h0fff, 2'h0, 16'h0);
    nop(2);
    chk("mode_word", 16'h0022, 16'(mode_word));
    cmd(4'h3, 2'h2, 13'h1abc, 2'h0, 16'h0);
    nop(1);
    chk("bank_open", 16'h4, 16'(bank_open));
    for (int i = 0; i < 4; i++) begin
      cmd(i == 0 ? 4'h4 : 4'h7, 2'h2, 13'h0005, i == 1 ? 2'h1 : 2'h0, 16'h1111 * 16'(i + 1));
      if (i > 0) chk("arr_row", 16'h1abc, 16'(arr_row));
      if (i > 0) chk("arr_col", 16'(4 + i % 4), 16'(arr_col));
      if (i > 0) chk("arr_bank", 16'h2, 16'(arr_bank));
    end
    nop(2);
    chk("bank_open", 16'h4, 16'(bank_open));
    for (int i = 0; i < 6; i++) begin
      cmd(i == 0 ? 4'h5 : 4'h7, 2'h2, 13'h0404, i == 2 ? 2'h2 : 2'h0, 16'h0);
      mk = (i == 4) ? 16'h00ff : 16'hffff;
      if (i > 1) chk("dq_out", rd_exp[i-2] & mk, dq_out & mk);
      if (i > 1) chk("dq_oe_n", (i == 4) ? 16'h2 : 16'h0, 16'(dq_oe_n));
    end
    nop(1);
    chk("dq_oe_n", 16'h3, 16'(dq_oe_n));
    chk("bank_open", 16'h0, 16'(bank_open));
    cmd(4'h3, 2'h0, 13'h0001, 2'h0, 16'h0);
    nop(1);
    cmd(4'h3, 2'h3, 13'h0002, 2'h0, 16'h0);
    cmd(4'h2, 2'h0, 13'h0000, 2'h0, 16'h0);
    nop(1);
    chk("bank_open", 16'h8, 16'(bank_open));
    cmd(4'h3, 2'h1, 13'h0003, 2'h0, 16'h0);
    cmd(4'h2, 2'h0, 13'h0400, 2'h0, 16'h0);
    nop(2);
    chk("bank_open", 16'h0, 16'(bank_open));
    cmd(4'h0, 2'h0, 13'h0027, 2'h0, 16'h0);
    nop(1);
    cmd(4'h3, 2'h1, 13'h0004, 2'h0, 16'h0);
    nop(1);
    cmd(4'h5, 2'h1, 13'h0400, 2'h0, 16'h0);
    nop(4);
    chk("arr_rd", 16'h1, 16'(arr_rd));
    cmd(4'h6, 2'h0, 13'h0000, 2'h0, 16'h0);
    nop(1);
    chk("arr_rd", 16'h0, 16'(arr_rd));
    chk("bank_open", 16'h2, 16'(bank_open));
    cmd(4'h2, 2'h0, 13'h0400, 2'h0, 16'h0);
    nop(2);
    cmd(4'h1, 2'h0, 13'h0000, 2'h0, 16'h0);
    cke = 1'b0;
    nop(1);
    chk("self_refresh", 16'h1, 16'(self_refresh));
    lk_run = 1'b0;
    repeat (10) @(negedge mclk);
    chk("self_refresh_seen", 16'h1, 16'(self_refresh_seen));
    r0 = refresh_row;
    n = 0;
    repeat (390) begin
      @(negedge mclk);
      if (refresh_pulse === 1'b1) n++;
    end
    chk("self refresh pulses", 16'h2, 16'(n));
    chk("refresh_row", 16'(r0 + 13'h2), 16'(refresh_row));
    lk_run = 1'b1;
    nop(2);
    cke = 1'b1;
    nop(3);
    chk("self_refresh", 16'h0, 16'(self_refresh));
    r0 = refresh_row;
    cmd(4'h1, 2'h3, 13'h1fff, 2'h0, 16'h0);
    nop(1);
    repeat (8) @(negedge mclk);
    chk("refresh_row", 16'(r0 + 13'h1), 16'(refresh_row));
    chk("self_refresh", 16'h0, 16'(self_refresh));
    cmd(4'h0, 2'h0, 13'h0030, 2'h0, 16'h0);
    nop(1);
    chk("mode_word", 16'h0030, 16'(mode_word));
    cmd(4'h3, 2'h0, 13'h0000, 2'h0, 16'h0);
    nop(1);
    cmd(4'h5, 2'h0, 13'h0005, 2'h0, 16'h0);
    nop(2);
    chk("dq_oe_n", 16'h3, 16'(dq_oe_n));
    nop(1);
    chk("dq_out", 16'h1111, dq_out);
    chk("dq_oe_n", 16'h0, 16'(dq_oe_n));
    close_out();
  end
endmodule
`default_nettype wire
